// ### sim/ioc_periph.sv
// Peripheral and memory model on the far side of the unit.
// Port side answers a four-phase handshake after a random pause.
`timescale 1ns/1ns
`default_nettype none
module ioc_periph (
  input wire logic ref_clk, // Clock
  input wire logic io_req, // Port request
  input wire logic [15:0] io_addr, // Port address
  input wire logic [7:0] io_wdata, // Port write data
  output logic io_ack, // Port answer
  output logic [7:0] io_rdata, // Port read data
  input wire logic mem_req, // Memory request
  input wire logic mem_wr, // Memory write
  input wire logic [15:0] mem_addr, // Memory address
  input wire logic [7:0] mem_wdata, // Memory write data
  output logic mem_ack, // Memory answer
  output logic [7:0] mem_rdata, // Memory read data
  input wire logic [7:0] dev_byte, // Byte returned on reads and acknowledge
  output logic [15:0] seen_addr, // Last port address
  output logic [7:0] seen_data, // Last port write data
  output int n_xfer // Port cycles served
);
  logic [7:0] mem [0:65535];
  int seed = 32'h352d23ed;
  initial begin
    io_ack = 1'b0;
    io_rdata = 8'h00;
    mem_ack = 1'b0;
    mem_rdata = 8'h00;
    n_xfer = 0;
  end
  // Port device; released data shows the inverse so stale values never match
  always begin
    @(negedge ref_clk);
    if (io_req === 1'b1) begin
      repeat (($random(seed) & 3) + 1) @(negedge ref_clk);
      seen_addr = io_addr;
      seen_data = io_wdata;
      n_xfer++;
      io_rdata = dev_byte;
      io_ack = 1'b1;
      while (io_req) @(negedge ref_clk);
      io_ack = 1'b0;
      io_rdata = ~io_rdata;
    end
  end
  // Memory, prompt or one cycle slow
  always begin
    @(negedge ref_clk);
    if (mem_req === 1'b1) begin
      repeat ($random(seed) & 1) @(negedge ref_clk);
      mem_rdata = mem[mem_addr];
      mem_ack = 1'b1;
      if (mem_wr) mem[mem_addr] = mem_wdata;
      @(posedge ref_clk);
      @(negedge ref_clk);
      mem_ack = 1'b0;
      mem_rdata = ~mem_rdata;
    end
  end
endmodule
`default_nettype wire

// ### sim/ioc_unit_sva.sv
// Port handshake and interrupt checks for the I/O and CPU control unit.
// Bound to ioc_unit from the bench top; sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module ioc_unit_sva (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Sync reset
  input wire logic io_req, // Port request
  input wire logic io_ack, // Port answer
  input wire logic io_inta, // Acknowledge cycle
  input wire logic [15:0] io_addr, // Port address
  input wire logic mem_req, // Memory request
  input wire logic mem_wr, // Memory write
  input wire logic mem_ack, // Memory answer
  input wire logic [15:0] mem_addr, // Memory address
  input wire logic halted, // Suspended
  input wire logic int_on, // Interrupts enabled
  input wire logic [1:0] vmode, // Vector mode
  input wire logic [7:0] reg_i, // Interrupt page
  input wire logic [15:0] pc // Program counter
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Handshake: address holds, request waits for and then follows the answer
  a_port_addr_hold: assert property (io_req && $past(io_req) |-> $stable(io_addr))
    else $error("port address moved during a request");
  a_req_waits_ack: assert property (io_req && !io_ack && !$past(io_ack) |=> io_req)
    else $error("port request dropped without an answer");
  a_ack_ends_req: assert property (io_req && io_ack |-> ##[1:4] !io_req)
    else $error("port request outlived the answer");
  a_mem_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("memory request not held until answer");
  // Suspension ends only through an accepted interrupt
  a_halt_stays: assert property (halted && !int_on |=> halted)
    else $error("left suspension with interrupts locked");
  a_inta_locks: assert property ($fell(io_req) && io_inta |-> !int_on)
    else $error("interrupts still enabled during acknowledge");
  a_inta_addr_pc: assert property ($rose(io_req) && io_inta |-> io_addr == pc)
    else $error("acknowledge address is not the counter");
  a_vm1_target: assert property ($rose(io_req) && io_inta && vmode == 2'h1
    |-> ##[1:60] pc == 16'h0038)
    else $error("mode one did not reach 0038");
  a_vm2_page: assert property ($rose(io_req) && io_inta && vmode == 2'h2
    |-> ##[1:60] (mem_req && !mem_wr && mem_addr[15:8] == reg_i))
    else $error("mode two table read not on interrupt page");
  c_vm2: cover property ($rose(io_req) && io_inta && vmode == 2'h2);
  c_wake: cover property (halted ##1 !halted);
  c_mem_wr: cover property (mem_req && mem_wr && mem_ack);
endmodule
`default_nettype wire

// ### sim/tb_io_and_cpu_control_instructions.sv
// Self-checking bench for the I/O and CPU control unit, random and corner cases.
// Assumes ioc_periph on the far side; inputs change on the falling edge.
`timescale 1ns/1ns
`default_nettype none
module tb_io_and_cpu_control_instructions;
  import ioc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ins_valid = 1'b0, ins_ed = 1'b0, ld_en = 1'b0, int_req = 1'b0;
  logic [7:0] ins_op = 8'h00, ins_imm = 8'h00, ld_data = 8'h00, dev_byte = 8'h00;
  logic [2:0] ld_sel = 3'h0;
  logic ins_ready, io_req, io_wr, io_inta, io_ack, mem_req, mem_wr, mem_ack;
  logic busy, halted, int_on, pv_flag;
  logic [1:0] vmode;
  logic [7:0] io_wdata, io_rdata, mem_wdata, mem_rdata, seen_data;
  logic [7:0] reg_a, reg_b, reg_c, reg_d, reg_e, reg_h, reg_l, reg_i;
  logic [15:0] io_addr, mem_addr, pc, sp, seen_addr;
  int n_errors = 0, n_checks = 0, n_xfer;
  int seed = 32'h352d23ed;
  logic [7:0] m [0:7];
  logic [7:0] ops [0:7] = '{8'hA2, 8'hAA, 8'hB2, 8'hBA, 8'hA3, 8'hAB, 8'hB3, 8'hBB};
  logic [7:0] vm [0:2] = '{8'h46, 8'h56, 8'h5E};
  logic [15:0] epc = 16'h0000, esp = 16'hFFFF;

  always #10 ref_clk = ~ref_clk;

  ioc_unit DUT (.ref_clk, .rst, .ins_valid, .ins_ready, .ins_ed, .ins_op, .ins_imm,
    .ld_en, .ld_sel, .ld_data, .io_req, .io_wr, .io_inta, .io_addr, .io_wdata, .io_ack,
    .io_rdata, .mem_req, .mem_wr, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .int_req,
    .busy, .halted, .int_on, .vmode, .pv_flag, .reg_a, .reg_b, .reg_c, .reg_d, .reg_e,
    .reg_h, .reg_l, .reg_i, .pc, .sp);
  ioc_periph P (.ref_clk, .io_req, .io_addr, .io_wdata, .io_ack, .io_rdata, .mem_req,
    .mem_wr, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata, .dev_byte, .seen_addr,
    .seen_data, .n_xfer);

  task automatic summarize();
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // A loop that ran out of its bound ends the run
  task automatic bound(input int r, input int lim);
    if (r >= lim) begin
      n_errors++;
      summarize();
    end
  endtask
  task automatic ld(input logic [2:0] s, input logic [7:0] v);
    @(negedge ref_clk);
    ld_en = 1'b1;
    ld_sel = s;
    ld_data = v;
    m[s] = v;
    @(negedge ref_clk);
    ld_en = 1'b0;
  endtask
  // One word for exactly one rising edge; expected counter follows its length
  task automatic send(input logic ed, input logic [7:0] op, input logic [7:0] imm);
    @(negedge ref_clk);
    ins_valid = 1'b1;
    ins_ed = ed;
    ins_op = op;
    ins_imm = imm;
    epc += (ed || op == 8'hDB || op == 8'hD3) ? 16'h0002 : 16'h0001;
    @(negedge ref_clk);
    ins_valid = 1'b0;
  endtask
  task automatic settle();
    int k, q;
    q = 0;
    for (k = 0; k < 20000 && q < 6; k++) begin
      @(negedge ref_clk);
      q = (busy === 1'b0 && io_req === 1'b0 && io_ack === 1'b0) ? q + 1 : 0;
    end
    bound(k, 20000);
  endtask
  task automatic run(input logic ed, input logic [7:0] op, input logic [7:0] imm);
    send(ed, op, imm);
    settle();
    chk(pc, epc);
  endtask
  function automatic logic [7:0] rv(input int r);
    case (r)
      0: return reg_b;
      1: return reg_c;
      2: return reg_d;
      3: return reg_e;
      4: return reg_h;
      5: return reg_l;
      6: return reg_i;
      default: return reg_a;
    endcase
  endfunction
  function automatic logic [7:0] pat(input logic [15:0] x);
    return x[7:0] ^ x[15:8] ^ 8'h5A;
  endfunction

  // Main sequence
  initial begin
    logic [7:0] v, c, b, op;
    logic [15:0] t, hl, last;
    int k, r, cnt, x0;
    for (k = 0; k < 65536; k++) P.mem[k] = pat(16'(k));
    for (k = 0; k < 8; k++) m[k] = 8'h00;
    repeat (6) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    chk(pc, 16'h0000);
    chk(sp, 16'hFFFF);
    chk({int_on, vmode, reg_a}, 16'h0000);
    run(1'b0, 8'h00, 8'h00);
    chk({reg_b, reg_c}, 16'h0000);
    // Immediate port: number low, accumulator high
    for (k = 0; k < 4; k++) begin
      v = 8'($random(seed));
      c = 8'($random(seed));
      ld(3'd7, v);
      run(1'b0, 8'hD3, c);
      chk(seen_addr, {v, c});
      chk(seen_data, v);
      dev_byte = 8'($random(seed));
      run(1'b0, 8'hDB, c);
      chk(seen_addr, {v, c});
      chk(reg_a, dev_byte);
      m[7] = dev_byte;
    end
    // Indirect read and write through every general register
    for (r = 0; r < 8; r++) begin
      ld(3'd0, 8'($random(seed)));
      ld(3'd1, 8'($random(seed)));
      t = {m[0], m[1]};
      dev_byte = 8'($random(seed));
      run(1'b1, 8'h40 | 8'(r << 3), 8'h00);
      chk(seen_addr, t);
      if (r != 6) m[r] = dev_byte;
      chk(rv(r), m[r]);
      chk(pv_flag, ~^dev_byte);
      run(1'b1, 8'h41 | 8'(r << 3), 8'h00);
      chk(seen_data, (r == 6) ? 8'h00 : m[r]);
    end
    // All block forms, then a repeating read with a zero count
    for (k = 0; k < 9; k++) begin
      op = (k < 8) ? ops[k] : 8'hB2;
      b = (k < 8) ? 8'(($random(seed) & 3) + 1) : 8'h00;
      cnt = op[4] ? ((b == 8'h00) ? 256 : int'(b)) : 1;
      hl = {op[0], 15'($random(seed))};
      ld(3'd0, b);
      ld(3'd1, 8'($random(seed)));
      ld(3'd4, hl[15:8]);
      ld(3'd5, hl[7:0]);
      dev_byte = 8'($random(seed));
      x0 = n_xfer;
      run(1'b1, op, 8'h00);
      last = op[3] ? hl - 16'(cnt - 1) : hl + 16'(cnt - 1);
      chk(16'(n_xfer - x0), 16'(cnt));
      chk({reg_h, reg_l}, op[3] ? last - 16'h0001 : last + 16'h0001);
      chk(reg_b, b - 8'(cnt));
      chk(seen_addr, {op[4] ? 8'h01 : b, m[1]});
      if (op[0]) chk(seen_data, pat(last));
      else chk(P.mem[last], dev_byte);
    end
    run(1'b0, 8'hFB, 8'h00);
    chk(int_on, 1'b1);
    run(1'b0, 8'hF3, 8'h00);
    chk(int_on, 1'b0);
    // Each vector mode: suspend, fill the queue, wake by interrupt
    for (k = 0; k < 3; k++) begin
      run(1'b1, vm[k], 8'h00);
      chk(vmode, 16'(k));
      ld(3'd6, 8'($random(seed)));
      t = 16'($random(seed));
      dev_byte = (k == 0) ? 8'hCF : 8'($random(seed));
      P.mem[{m[6], dev_byte}] = t[7:0];
      P.mem[{m[6], dev_byte} + 16'h0001] = t[15:8];
      if (k != 2) t = (k == 0) ? 16'h0008 : 16'h0038;
      run(1'b0, 8'hFB, 8'h00);
      send(1'b0, 8'h76, 8'h00);
      hl = epc;
      for (r = 0; r < 50 && halted !== 1'b1; r++) @(negedge ref_clk);
      bound(r, 50);
      for (r = 0; r < 40 && ins_ready === 1'b1; r++) send(1'b0, 8'h00, 8'h00);
      chk(16'(r), 16'd32);
      chk(halted, 1'b1);
      int_req = 1'b1;
      for (r = 0; r < 300 && !(io_inta === 1'b1 && io_req === 1'b1); r++) @(negedge ref_clk);
      bound(r, 300);
      int_req = 1'b0;
      settle();
      epc = t + 16'd32;
      esp = esp - 16'd2;
      chk(pc, epc);
      chk(sp, esp);
      chk({P.mem[esp + 16'd1], P.mem[esp]}, hl);
      chk({halted, int_on}, 16'h0000);
    end
    // Locked out: suspension cannot end
    run(1'b0, 8'hF3, 8'h00);
    send(1'b0, 8'h76, 8'h00);
    int_req = 1'b1;
    repeat (30) @(negedge ref_clk);
    chk(halted, 1'b1);
    summarize();
  end
endmodule
bind ioc_unit ioc_unit_sva u_sva (.ref_clk, .rst, .io_req, .io_ack, .io_inta, .io_addr,
  .mem_req, .mem_wr, .mem_ack, .mem_addr, .halted, .int_on, .vmode, .reg_i, .pc);
`default_nettype wire

// ### verilog/ioc_params.svh
// Constants for the port I/O and CPU control execution unit.
// Included by the unit only; definitions only.
`ifndef IOC_PARAMS_SVH
`define IOC_PARAMS_SVH

// Opcodes
`define IOC_OP_NOP 8'h00
`define IOC_OP_HALT 8'h76
`define IOC_OP_LOCK 8'hF3
`define IOC_OP_EN 8'hFB
`define IOC_OP_IN_IMM 8'hDB
`define IOC_OP_OUT_IMM 8'hD3
`define IOC_OP_VM0 8'h46
`define IOC_OP_VM1 8'h56
`define IOC_OP_VM2 8'h5E
// Field positions inside a block opcode
`define IOC_BLK_OUT_BIT 0
`define IOC_BLK_DOWN_BIT 3
`define IOC_BLK_REP_BIT 4
// Restart target field
`define IOC_RST_MASK 8'h38
// Fixed service address for vector mode one
`define IOC_VEC_ONE 16'h0038
// Reset values
`define IOC_PC_RST 16'h0000
`define IOC_SP_RST 16'hFFFF
`define IOC_REG_RST 8'h00
// Instruction FIFO
`define IOC_FIFO_DEPTH 32
`define IOC_INS_W 17

`endif

// ### verilog/ioc_pkg.sv
// Types shared by the port I/O and CPU control execution unit.
// Needs nothing from the constants header.
`default_nettype none
package ioc_pkg;
  typedef enum logic [1:0] {
    ioc_vm_zero,
    ioc_vm_one,
    ioc_vm_two
  } ioc_vmode_t;

  typedef enum logic [3:0] {
    IOC_FETCH,
    IOC_EXEC,
    IOC_IO,
    IOC_INTA,
    IOC_IO_END,
    IOC_MRD,
    IOC_MWR,
    IOC_STEP,
    IOC_VEC_L,
    IOC_VEC_H,
    IOC_PUSH_H,
    IOC_PUSH_L,
    IOC_HALT
  } ioc_state_t;
endpackage
`default_nettype wire

// ### verilog/ioc_unit.sv
// Port I/O and CPU control execution unit, with its instruction FIFO.
// Assumes a peripheral on a four-phase port handshake in another domain,
// and a memory that answers on ref_clk with mem_ack.
`timescale 1ns/1ns
`default_nettype none
`include "ioc_params.svh"

module ioc_fifo #(
  parameter int W = `IOC_INS_W,
  parameter int DEPTH = `IOC_FIFO_DEPTH
) (
  input wire logic ref_clk,          // Clock
  input wire logic rst,              // Synchronous reset
  input wire logic in_valid,         // Write request
  output logic in_ready,             // Space available
  input wire logic [W-1:0] in_data,  // Write word
  output logic out_valid,            // Word available
  input wire logic out_ready,        // Read request
  output logic [W-1:0] out_data      // Oldest word
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0] wptr;
  logic [AW:0] rptr;

  // Extra pointer bit tells full from empty
  assign out_valid = wptr != rptr;
  assign in_ready = (wptr[AW-1:0] != rptr[AW-1:0]) || (wptr[AW] == rptr[AW]);
  assign out_data = mem[rptr[AW-1:0]];

  // Storage write
  always_ff @(posedge ref_clk) begin
    if (in_valid && in_ready) begin
      mem[wptr[AW-1:0]] <= in_data;
    end
  end

  // Pointers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wptr <= wptr + 1'b1;
      end
      if (out_valid && out_ready) begin
        rptr <= rptr + 1'b1;
      end
    end
  end
endmodule

module ioc_unit
  import ioc_pkg::*;
(
  input wire logic ref_clk,          // Clock, 50 MHz
  input wire logic rst,              // Synchronous reset
  input wire logic ins_valid,        // Instruction offered
  output logic ins_ready,            // FIFO has room
  input wire logic ins_ed,           // ED prefix present
  input wire logic [7:0] ins_op,     // Opcode byte
  input wire logic [7:0] ins_imm,    // Immediate port number
  input wire logic ld_en,            // Register preset strobe
  input wire logic [2:0] ld_sel,     // Preset target, register code
  input wire logic [7:0] ld_data,    // Preset value
  output logic io_req,               // Port cycle request
  output logic io_wr,                // Port cycle is a write
  output logic io_inta,              // Port cycle is acknowledge
  output logic [15:0] io_addr,       // Port address bus
  output logic [7:0] io_wdata,       // Port write data
  input wire logic io_ack,           // Port answer, async
  input wire logic [7:0] io_rdata,   // Port read data, async
  output logic mem_req,              // Memory request
  output logic mem_wr,               // Memory write
  output logic [15:0] mem_addr,      // Memory address
  output logic [7:0] mem_wdata,      // Memory write data
  input wire logic mem_ack,          // Memory answer
  input wire logic [7:0] mem_rdata,  // Memory read data
  input wire logic int_req,          // Maskable interrupt, async
  output logic busy,                 // Not waiting for an opcode
  output logic halted,               // Suspended until interrupt
  output logic int_on,               // Maskable interrupts enabled
  output logic [1:0] vmode,          // Vector mode
  output logic pv_flag,              // Parity flag
  output logic [7:0] reg_a,          // Accumulator
  output logic [7:0] reg_b,          // Counter
  output logic [7:0] reg_c,          // Port register
  output logic [7:0] reg_d,          // General register
  output logic [7:0] reg_e,          // General register
  output logic [7:0] reg_h,          // Pointer high
  output logic [7:0] reg_l,          // Pointer low
  output logic [7:0] reg_i,          // Interrupt page
  output logic [15:0] pc,            // Program counter
  output logic [15:0] sp             // Stack pointer
);
  ioc_state_t state;
  ioc_vmode_t mode;
  logic [`IOC_INS_W-1:0] f_data;
  logic f_valid;
  logic f_ready;
  logic cur_ed;
  logic [7:0] cur_op;
  logic [7:0] cur_imm;
  logic [7:0] dbuf;
  logic [15:0] tgt;
  logic [1:0] ack_sync;
  logic [1:0] irq_sync;
  logic [7:0] rd_meta;
  logic [7:0] rd_sync;
  logic ack_s;
  logic irq_s;
  logic take;
  logic irq_go;
  logic [1:0] f_len;
  logic is_blk;
  logic is_ind;
  logic is_rst;
  logic is_imm_in;
  logic is_imm_out;
  logic blk_again;
  logic io_done;
  logic mem_done;
  logic [15:0] hl;
  logic [15:0] next_hl;
  logic [15:0] tgt_pc_q;

  // Opcode stream buffer; it stalls the source only while all 32 entries are full
  ioc_fifo #(.W(`IOC_INS_W), .DEPTH(`IOC_FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_valid(ins_valid),
    .in_ready(ins_ready),
    .in_data({ins_ed, ins_op, ins_imm}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Pin inputs pass two flops; data is held stable while ack is high
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_sync <= 2'h0;
      irq_sync <= 2'h0;
      rd_meta <= 8'h00;
      rd_sync <= 8'h00;
    end else begin
      ack_sync <= {ack_sync[0], io_ack};
      irq_sync <= {irq_sync[0], int_req};
      rd_meta <= io_rdata;
      rd_sync <= rd_meta;
    end
  end
  assign ack_s = ack_sync[1];
  assign irq_s = irq_sync[1];

  // Decode of the current opcode
  assign is_imm_in = !cur_ed && cur_op == `IOC_OP_IN_IMM;
  assign is_imm_out = !cur_ed && cur_op == `IOC_OP_OUT_IMM;
  assign is_ind = cur_ed && cur_op[7:6] == 2'h1 && cur_op[2:1] == 2'h0;
  assign is_blk = cur_ed && cur_op[7:5] == 3'h5 && cur_op[2:1] == 2'h1;
  assign is_rst = !cur_ed && cur_op[7:6] == 2'h3 && cur_op[2:0] == 3'h7;
  // Counter of one decrements to zero and stops; zero wraps to 255 and runs on
  assign blk_again = cur_op[`IOC_BLK_REP_BIT] && reg_b != 8'h01;
  assign hl = {reg_h, reg_l};
  assign next_hl = cur_op[`IOC_BLK_DOWN_BIT] ? hl - 16'h0001 : hl + 16'h0001;

  assign irq_go = irq_s && int_on;
  assign take = state == IOC_FETCH && !irq_go && f_valid;
  assign f_ready = take;
  assign f_len = 2'h1 + {1'b0, f_data[16]} + {1'b0, !f_data[16] &&
    (f_data[15:8] == `IOC_OP_IN_IMM || f_data[15:8] == `IOC_OP_OUT_IMM)};
  assign io_done = state == IOC_IO_END && !ack_s;
  assign mem_done = mem_req && mem_ack;

  // Handshake strobes follow the state directly
  assign io_req = state == IOC_IO || state == IOC_INTA;
  assign mem_req = state inside {IOC_MRD, IOC_MWR, IOC_VEC_L, IOC_VEC_H, IOC_PUSH_H,
    IOC_PUSH_L};
  assign mem_wr = state inside {IOC_MWR, IOC_PUSH_H, IOC_PUSH_L};
  assign busy = state != IOC_FETCH;
  assign halted = state == IOC_HALT;
  assign vmode = mode;
  assign pc = tgt_pc_q;

  // General register read by code
  function automatic logic [7:0] reg_rd(input logic [2:0] sel, input logic [7:0] a,
      input logic [7:0] b, input logic [7:0] c, input logic [7:0] d, input logic [7:0] e,
      input logic [7:0] h, input logic [7:0] l);
    case (sel)
      3'h0: reg_rd = b;
      3'h1: reg_rd = c;
      3'h2: reg_rd = d;
      3'h3: reg_rd = e;
      3'h4: reg_rd = h;
      3'h5: reg_rd = l;
      3'h7: reg_rd = a;
      default: reg_rd = 8'h00;
    endcase
  endfunction

  // Sequencer and bus data; addresses are loaded as each cycle is entered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= IOC_FETCH;
      cur_ed <= 1'b0;
      cur_op <= `IOC_OP_NOP;
      cur_imm <= 8'h00;
      dbuf <= 8'h00;
      tgt <= `IOC_PC_RST;
      io_wr <= 1'b0;
      io_inta <= 1'b0;
      io_addr <= 16'h0000;
      io_wdata <= 8'h00;
      mem_addr <= 16'h0000;
      mem_wdata <= 8'h00;
    end else begin
      case (state)
        IOC_FETCH, IOC_HALT: begin
          if (irq_go) begin
            io_addr <= tgt_pc_q;
            io_wr <= 1'b0;
            io_inta <= 1'b1;
            state <= IOC_INTA;
          end else if (take) begin
            {cur_ed, cur_op, cur_imm} <= f_data;
            state <= IOC_EXEC;
          end
        end
        IOC_EXEC: begin
          if (is_imm_in || is_imm_out) begin
            io_addr <= {reg_a, cur_imm};
            io_wdata <= reg_a;
            io_wr <= is_imm_out;
            state <= IOC_IO;
          end else if (is_ind) begin
            io_addr <= {reg_b, reg_c};
            io_wdata <= reg_rd(cur_op[5:3], reg_a, reg_b, reg_c, reg_d, reg_e, reg_h, reg_l);
            io_wr <= cur_op[`IOC_BLK_OUT_BIT];
            state <= IOC_IO;
          end else if (is_blk && cur_op[`IOC_BLK_OUT_BIT]) begin
            mem_addr <= hl;
            state <= IOC_MRD;
          end else if (is_blk) begin
            io_addr <= {reg_b, reg_c};
            io_wr <= 1'b0;
            state <= IOC_IO;
          end else if (is_rst) begin
            tgt <= {8'h00, cur_op & `IOC_RST_MASK};
            mem_addr <= sp - 16'h0001;
            mem_wdata <= tgt_pc_q[15:8];
            state <= IOC_PUSH_H;
          end else if (!cur_ed && cur_op == `IOC_OP_HALT) begin
            state <= IOC_HALT;
          end else begin
            state <= IOC_FETCH;
          end
        end
        IOC_IO, IOC_INTA: begin
          if (ack_s) begin
            if (!io_wr) begin
              dbuf <= rd_sync;
            end
            state <= IOC_IO_END;
          end
        end
        IOC_IO_END: begin
          if (!ack_s && io_inta) begin
            io_inta <= 1'b0;
            case (mode)
              ioc_vm_zero: begin
                cur_ed <= 1'b0;
                cur_op <= dbuf;
                state <= IOC_EXEC;
              end
              ioc_vm_one: begin
                tgt <= `IOC_VEC_ONE;
                mem_addr <= sp - 16'h0001;
                mem_wdata <= tgt_pc_q[15:8];
                state <= IOC_PUSH_H;
              end
              default: begin
                mem_addr <= {reg_i, dbuf};
                state <= IOC_VEC_L;
              end
            endcase
          end else if (!ack_s && is_blk && !io_wr) begin
            mem_addr <= hl;
            mem_wdata <= dbuf;
            state <= IOC_MWR;
          end else if (!ack_s) begin
            state <= is_blk ? IOC_STEP : IOC_FETCH;
          end
        end
        IOC_MRD: begin
          if (mem_ack) begin
            io_wdata <= mem_rdata;
            io_addr <= {reg_b, reg_c};
            io_wr <= 1'b1;
            state <= IOC_IO;
          end
        end
        IOC_MWR: begin
          if (mem_ack) begin
            state <= IOC_STEP;
          end
        end
        IOC_STEP: begin
          state <= blk_again ? IOC_EXEC : IOC_FETCH;
        end
        IOC_VEC_L: begin
          if (mem_ack) begin
            tgt[7:0] <= mem_rdata;
            mem_addr <= {reg_i, dbuf} + 16'h0001; // Second byte may carry into next page
            state <= IOC_VEC_H;
          end
        end
        IOC_VEC_H: begin
          if (mem_ack) begin
            tgt[15:8] <= mem_rdata;
            mem_addr <= sp - 16'h0001;
            mem_wdata <= tgt_pc_q[15:8];
            state <= IOC_PUSH_H;
          end
        end
        IOC_PUSH_H: begin
          if (mem_ack) begin
            mem_addr <= sp - 16'h0002;
            mem_wdata <= tgt_pc_q[7:0];
            state <= IOC_PUSH_L;
          end
        end
        IOC_PUSH_L: begin
          if (mem_ack) begin
            state <= IOC_FETCH;
          end
        end
        default: state <= IOC_FETCH;
      endcase
    end
  end

  // Program counter, stack pointer and interrupt control
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tgt_pc_q <= `IOC_PC_RST;
      sp <= `IOC_SP_RST;
      int_on <= 1'b0;
      mode <= ioc_vm_zero;
    end else begin
      if (take) begin
        tgt_pc_q <= tgt_pc_q + {14'h0000, f_len};
      end
      if (state == IOC_EXEC && !cur_ed && cur_op == `IOC_OP_LOCK) begin
        int_on <= 1'b0;
      end else if (state == IOC_EXEC && !cur_ed && cur_op == `IOC_OP_EN) begin
        int_on <= 1'b1;
      end else if (state == IOC_INTA && ack_s) begin
        int_on <= 1'b0;
      end
      if (state == IOC_EXEC && cur_ed) begin
        case (cur_op)
          `IOC_OP_VM0: mode <= ioc_vm_zero;
          `IOC_OP_VM1: mode <= ioc_vm_one;
          `IOC_OP_VM2: mode <= ioc_vm_two;
          default: mode <= mode;
        endcase
      end
      if (mem_done && (state == IOC_PUSH_H || state == IOC_PUSH_L)) begin
        sp <= sp - 16'h0001;
      end
      if (mem_done && state == IOC_PUSH_L) begin
        tgt_pc_q <= tgt;
      end
    end
  end

  // General registers: presets, port reads and block stepping
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      {reg_a, reg_b, reg_c, reg_d} <= {4{`IOC_REG_RST}};
      {reg_e, reg_h, reg_l, reg_i} <= {4{`IOC_REG_RST}};
      pv_flag <= 1'b0;
    end else if (ld_en) begin
      // Presets are meant for idle periods and win over execution
      case (ld_sel)
        3'h0: reg_b <= ld_data;
        3'h1: reg_c <= ld_data;
        3'h2: reg_d <= ld_data;
        3'h3: reg_e <= ld_data;
        3'h4: reg_h <= ld_data;
        3'h5: reg_l <= ld_data;
        3'h6: reg_i <= ld_data;
        default: reg_a <= ld_data;
      endcase
    end else if (io_done && !io_inta && !io_wr && is_imm_in) begin
      reg_a <= dbuf;
    end else if (io_done && !io_inta && !io_wr && is_ind) begin
      pv_flag <= ~^dbuf;
      case (cur_op[5:3])
        3'h0: reg_b <= dbuf;
        3'h1: reg_c <= dbuf;
        3'h2: reg_d <= dbuf;
        3'h3: reg_e <= dbuf;
        3'h4: reg_h <= dbuf;
        3'h5: reg_l <= dbuf;
        3'h7: reg_a <= dbuf;
        default: pv_flag <= ~^dbuf;
      endcase
    end else if (state == IOC_STEP) begin
      reg_b <= reg_b - 8'h01;
      {reg_h, reg_l} <= next_hl;
    end
  end
endmodule

`default_nettype wire

// ### verilog/ioc_unit_fix_note.sv
// Holds no logic; the unit and its FIFO sit in ioc_unit.sv.
// Assumes nothing of its surroundings.
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire
